/* File: src/vrc_defs.svh */
`ifndef VRC_DEFS_SVH
`define VRC_DEFS_SVH
`define VRC_REF_CTRL_ADDR    8'hD1
`define VRC_REF_CTRL_RESET   8'h00
`define VRC_REF_CTRL_MASK    8'h0E
`define VRC_BIT_REF_SEL      3
`define VRC_BIT_TEMP_EN      2
`define VRC_BIT_BIAS_EN      1
`define VRC_TEMP_MUX_SEL     4'h8
`define VRC_SAR_MIN_CLOCKS   11
`define VRC_SAR_MAX_MHZ      6
`define VRC_SYSCLK_MHZ       100
`define VRC_DIV_MIN          5'h10
`endif

/* File: src/vrc_pkg.sv */
package vrc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } vrc_bus_s;
endpackage

/* File: src/vrc_reference_control.sv */
// Operation
// - Bit 3 routes external pin at 0, supply at 1, to reference.
// - Bit 2 switches the temperature sensor off at 0, on at 1.
// - Disabled sensor output is high impedance; its conversions are invalid.
// - Effective bias enable forced high by ADC, sensor or oscillator enable.
// - Writing 1 to bias bit turns bias on without any dependent peripheral.
// - Bits 7 to 4 and 0 read zero; writes to them ignored.
// - Sensor sits on ADC positive mux selection 8 (4'h8).
// - Conversion lasts at least 11 SAR clocks; SAR clock at most 6 MHz (not enforced: i_sar_divider below 16 runs it faster).
// - SAR clock equals system clock divided by divider field plus one.
`include "vrc_defs.svh"
module vrc_reference_control
  import vrc_pkg::*;
(
  input  wire logic       i_mclk,           // System clock.
  input  wire logic       i_resetn,         // Async reset, active low.
  input  wire vrc_bus_s   i_bus,            // Register bus request.
  output logic [7:0]      o_rdata,          // Read data, registered.
  input  wire logic       i_adc_enable,     // ADC enabled.
  input  wire logic       i_osc_enable,     // Internal oscillator enabled.
  input  wire logic [3:0] i_adc_pos_sel,    // ADC positive mux selection.
  input  wire logic [4:0] i_sar_divider,    // SAR clock divider field.
  input  wire logic       i_adc_start,      // Conversion start pulse.
  output logic            o_ref_use_supply, // Reference taken from supply.
  output logic            o_ref_pin_route,  // External pin routed to reference.
  output logic            o_temp_sensor_on, // Temperature sensor powered.
  output logic            o_temp_out_oe,    // Sensor output drives its node.
  output logic            o_temp_selected,  // Mux selects the sensor.
  output logic            o_sample_invalid, // Sensor sampled while off.
  output logic            o_bias_on,        // Effective bias enable.
  output logic            o_sar_clk_tick,   // SAR clock tick pulse.
  output logic            o_conv_busy,      // Conversion in progress.
  output logic            o_conv_done       // Conversion finished pulse.
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] rdata_reg, rdata_next;

  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = rdata_reg;
    if (i_bus.wr && i_bus.addr == `VRC_REF_CTRL_ADDR) begin
      ctrl_next = i_bus.wdata & `VRC_REF_CTRL_MASK;
    end
    if (i_bus.rd) begin
      rdata_next = (i_bus.addr == `VRC_REF_CTRL_ADDR) ? ctrl_reg : 8'h00;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_reg  <= `VRC_REF_CTRL_RESET;
      rdata_reg <= 8'h00;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // reference source mux, sensor enable, sensor mux select and bias
  assign o_ref_use_supply = ctrl_reg[`VRC_BIT_REF_SEL];
  assign o_ref_pin_route  = ~ctrl_reg[`VRC_BIT_REF_SEL];
  assign o_temp_sensor_on = ctrl_reg[`VRC_BIT_TEMP_EN];
  assign o_temp_out_oe    = ctrl_reg[`VRC_BIT_TEMP_EN];
  assign o_temp_selected  = (i_adc_pos_sel == `VRC_TEMP_MUX_SEL);
  assign o_bias_on = ctrl_reg[`VRC_BIT_BIAS_EN] | i_adc_enable
                   | ctrl_reg[`VRC_BIT_TEMP_EN] | i_osc_enable;

  ////////////////////////////////////////////////////////////////////////////
  // The conversion timer models SAR pacing only; sampling is analog.
  logic [4:0] div_reg, div_next;
  logic [3:0] bit_reg, bit_next;
  logic       busy_reg, busy_next;
  logic       done_reg, done_next;
  logic       inval_reg, inval_next;
  logic       tick;

  assign tick = (div_reg == i_sar_divider);

  always_comb begin
    div_next   = tick ? 5'h00 : div_reg + 5'h01;
    bit_next   = bit_reg;
    busy_next  = busy_reg;
    done_next  = 1'b0;
    inval_next = inval_reg;
    if (!busy_reg && i_adc_start) begin
      busy_next  = 1'b1;
      bit_next   = 4'h0;
      inval_next = o_temp_selected & ~ctrl_reg[`VRC_BIT_TEMP_EN];
    end else if (busy_reg && tick) begin
      if (bit_reg == 4'(`VRC_SAR_MIN_CLOCKS - 1)) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        bit_next = bit_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg   <= 5'h00;
      bit_reg   <= 4'h0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      inval_reg <= 1'b0;
    end else begin
      div_reg   <= div_next;
      bit_reg   <= bit_next;
      busy_reg  <= busy_next;
      done_reg  <= done_next;
      inval_reg <= inval_next;
    end
  end

  assign o_sar_clk_tick   = tick;
  assign o_conv_busy      = busy_reg;
  assign o_conv_done      = done_reg;
  assign o_sample_invalid = inval_reg;

  // helper tick count
  // The checker counts ticks on its own, so a slip in the bit counter still shows.
  logic [3:0] conv_ticks_reg, conv_ticks_next;

  always_comb begin
    conv_ticks_next = conv_ticks_reg;
    if (!busy_reg && i_adc_start) begin
      conv_ticks_next = 4'h0;
    end else if (busy_reg && tick && conv_ticks_reg != 4'hF) begin
      conv_ticks_next = conv_ticks_reg + 4'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      conv_ticks_reg <= 4'h0;
    end else begin
      conv_ticks_reg <= conv_ticks_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_unused_zero;
    @(posedge i_mclk) disable iff (!i_resetn) (ctrl_reg & ~`VRC_REF_CTRL_MASK) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

  property p_readback;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_bus.rd && i_bus.addr == `VRC_REF_CTRL_ADDR) |=> o_rdata == $past(ctrl_reg);
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong");

  property p_bias_force;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_adc_enable || i_osc_enable || o_temp_sensor_on) |-> o_bias_on;
  endproperty
  a_bias_force: assert property (p_bias_force) else $error("bias not forced");

  property p_bias_manual;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_bus.wr && i_bus.addr == `VRC_REF_CTRL_ADDR && i_bus.wdata[1]) |=> o_bias_on;
  endproperty
  a_bias_manual: assert property (p_bias_manual) else $error("manual bias off");

  property p_ref_write;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_bus.wr && i_bus.addr == `VRC_REF_CTRL_ADDR)
        |=> (o_ref_use_supply == $past(i_bus.wdata[3])) && (o_ref_pin_route != o_ref_use_supply);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("ref select wrong");

  property p_temp_write;
    @(posedge i_mclk) disable iff (!i_resetn)
      (i_bus.wr && i_bus.addr == `VRC_REF_CTRL_ADDR)
        |=> (o_temp_sensor_on == $past(i_bus.wdata[2])) && (o_temp_out_oe == o_temp_sensor_on);
  endproperty
  a_temp_write: assert property (p_temp_write) else $error("sensor enable wrong");

  property p_mux_sel;
    @(posedge i_mclk) disable iff (!i_resetn) o_temp_selected == (i_adc_pos_sel == 4'h8);
  endproperty
  a_mux_sel: assert property (p_mux_sel) else $error("sensor mux wrong");

  sequence s_start;
    !busy_reg && i_adc_start;
  endsequence
  property p_conv_len;
    @(posedge i_mclk) disable iff (!i_resetn) s_start |=> o_conv_busy [*8];
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion too short");

  property p_conv_ticks;
    @(posedge i_mclk) disable iff (!i_resetn)
      $fell(o_conv_busy) |-> (conv_ticks_reg == 4'(`VRC_SAR_MIN_CLOCKS)) && o_conv_done;
  endproperty
  a_conv_ticks: assert property (p_conv_ticks) else $error("conversion tick count wrong");

  property p_invalid_set;
    @(posedge i_mclk) disable iff (!i_resetn)
      (!busy_reg && i_adc_start && o_temp_selected && !o_temp_sensor_on) |=> o_sample_invalid;
  endproperty
  a_invalid_set: assert property (p_invalid_set) else $error("invalid flag not set");

  property p_invalid_clr;
    @(posedge i_mclk) disable iff (!i_resetn)
      (!busy_reg && i_adc_start && !(o_temp_selected && !o_temp_sensor_on))
        |=> !o_sample_invalid;
  endproperty
  a_invalid_clr: assert property (p_invalid_clr) else $error("invalid flag set");

  // The gap holds only while the divider stays at its minimum for a whole period.
  sequence s_tick_gap;
    !tick [*8] ##1 !tick [*8];
  endsequence
  property p_tick_period;
    @(posedge i_mclk) disable iff (!i_resetn)
      (tick && i_sar_divider == `VRC_DIV_MIN) |=> s_tick_gap ##1 tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("sar divide wrong");
endmodule

/* File: verification/tb_top.sv */
`include "vrc_defs.svh"
module tb_top
  import vrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       i_mclk   = 1'b0;
  logic       i_resetn = 1'b0;
  vrc_bus_s   bus      = '0;
  logic       adc      = 1'b0;
  logic       osc      = 1'b0;
  logic       start    = 1'b0;
  logic [3:0] sel      = 4'h0;
  logic [4:0] div      = 5'h00;
  logic [7:0] rdata;
  logic       sup, pin, ton, toe, tsel, inv, bias, tick, busy, done;
  int         error_cnt = 0;
  int         checked   = 0;
  int         cyc       = 0;
  logic [7:0] pat [6] = '{8'hFF, 8'h08, 8'h04, 8'h02, 8'hF1, 8'h00};

  vrc_reference_control uut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_bus(bus),
    .o_rdata(rdata), .i_adc_enable(adc), .i_osc_enable(osc), .i_adc_pos_sel(sel),
    .i_sar_divider(div), .i_adc_start(start), .o_ref_use_supply(sup),
    .o_ref_pin_route(pin), .o_temp_sensor_on(ton), .o_temp_out_oe(toe),
    .o_temp_selected(tsel), .o_sample_invalid(inv), .o_bias_on(bias),
    .o_sar_clk_tick(tick), .o_conv_busy(busy), .o_conv_done(done));

  always #5 i_mclk = ~i_mclk;

  // The ceiling sits far above the few hundred cycles the scenarios need.
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk) bus <= '0;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk) bus <= '0;
    #1 d = rdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    logic [7:0] q;
    rd(`VRC_REF_CTRL_ADDR, q);
    chk(q, `VRC_REF_CTRL_RESET);
    chk({4'h0, sup, pin, ton, toe}, 8'h04);
  endtask

  task t_regs;
    logic [7:0] q;
    for (int i = 0; i < 6; i++) begin
      wr(`VRC_REF_CTRL_ADDR, pat[i]);
      rd(`VRC_REF_CTRL_ADDR, q);
      chk(q, pat[i] & `VRC_REF_CTRL_MASK);
      chk({4'h0, sup, pin, ton, toe},
          {4'h0, pat[i][3], ~pat[i][3], pat[i][2], pat[i][2]});
    end
    // A write to the neighbouring address must not leak into the register.
    wr(8'hD0, 8'hFF);
    rd(`VRC_REF_CTRL_ADDR, q);
    chk(q, 8'h00);
    rd(8'hD0, q);
    chk(q, 8'h00);
  endtask

  task t_bias;
    logic [7:0] q;
    for (int i = 0; i < 16; i++) begin
      wr(`VRC_REF_CTRL_ADDR, {5'h00, i[3], i[2], 1'b0});
      adc <= i[1];
      osc <= i[0];
      @(posedge i_mclk);
      #1 chk(8'(bias), 8'(|i[3:0]));
      rd(`VRC_REF_CTRL_ADDR, q);
      chk(q, {5'h00, i[3], i[2], 1'b0});
    end
    @(posedge i_mclk) adc <= 1'b0;
    osc <= 1'b0;
  endtask

  task t_conv(input logic [4:0] d, input logic en);
    int n;
    wr(`VRC_REF_CTRL_ADDR, {5'h00, en, 2'b10});
    sel <= 4'h8;
    div <= d;
    @(posedge i_mclk);
    #1 chk(8'(tsel), 8'h01);
    repeat (2) begin
      n = 0;
      do begin
        @(posedge i_mclk);
        #1 n++;
      end while (tick !== 1'b1 && n < 40);
    end
    chk(8'(n), 8'(d + 1));
    @(posedge i_mclk) start <= 1'b1;
    @(posedge i_mclk) start <= 1'b0;
    #1 chk({6'h00, busy, inv}, {6'h00, 1'b1, ~en});
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge i_mclk);
      #1 n++;
    end
    chk(8'(n >= 10 * (d + 1) && n <= 11 * (d + 1) + 2), 8'h01);
    chk(8'(busy), 8'h00);
    @(posedge i_mclk) sel <= 4'h9;
    @(posedge i_mclk);
    #1 chk(8'(tsel), 8'h00);
  endtask

  task t_midrst;
    logic [7:0] q;
    wr(`VRC_REF_CTRL_ADDR, 8'h0E);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1 chk(rdata, 8'h00);
    chk(8'(bias), 8'h00);
    @(posedge i_mclk) i_resetn <= 1'b1;
    rd(`VRC_REF_CTRL_ADDR, q);
    chk(q, `VRC_REF_CTRL_RESET);
    chk({4'h0, sup, pin, ton, toe}, 8'h04);
  endtask

  task results;
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge i_mclk);
    i_resetn <= 1'b1;
    t_reset();
    t_regs();
    t_bias();
    t_midrst();
    // The SAR clock stays at or below its ceiling; the minimum divider runs last.
    t_conv(`VRC_DIV_MIN + 5'h01, 1'b1);
    t_conv(`VRC_DIV_MIN, 1'b0);
    results();
  end
endmodule
